//--- design/nwl_top.sv
// network watchdog, logic combiner and option-card status outputs
`timescale 1ns/100ps
// How it works
// R1 - watchdog supervises serial traffic, programmable timeout
// R2 - code 08 output on after silence
// R3 - output stays off while traffic keeps arriving
// R4 - error response picks trip, stop or coast
// R5 - combiner inputs select any other output
// R6 - operator codes: 00 AND, 01 OR, 02 XOR
// R7 - code 09 output follows combiner result
// R8 - code 10 on while card network ok
// R9 - option card uses its own timeout
// R10 - feedback limits never raise an alarm
// R11 - every activity restarts the watchdog count
module nwl_top
  import nwl_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC  // cycles per 10 ms
) (
  input  wire logic                sys_clk_i,
  input  wire logic                resetn_i,
  // ahb-lite slave
  input  wire logic                hsel_i,
  input  wire logic [31:0]         haddr_i,
  input  wire logic [1:0]          htrans_i,
  input  wire logic                hwrite_i,
  input  wire logic [2:0]          hsize_i,
  input  wire logic [31:0]         hwdata_i,
  input  wire logic                hready_i,
  output logic                     hreadyout_o,
  output logic                     hresp_o,
  output logic [31:0]              hrdata_o,
  // pins
  input  wire logic                net_rx_i,
  input  wire logic                opt_beat_i,
  input  wire logic                opt_present_i,
  // other output functions from the drive, same clock
  input  wire logic [DRV_FN_W-1:0] drive_func_i,
  input  wire logic                second_stage_request_i,
  // outputs
  output logic [TERM_COUNT-1:0]    out_term_o,
  output logic                     trip_o,
  output logic [7:0]               trip_code_o,
  output logic                     stop_motor_o,
  output logic                     coast_o,
  output logic                     irq_o
);
  // configuration registers
  logic [2:0]       comm_error_response_r;  // timeout response
  logic [TMO_W-1:0] net_timeout_period_r;   // serial watchdog period
  logic [TMO_W-1:0] option_card_timeout_r;  // option card period
  logic [3:0]       comb_a_sel_r;           // combiner input a
  logic [3:0]       comb_b_sel_r;           // combiner input b
  logic [1:0]       comb_op_sel_r;          // combiner operator
  logic [3:0]       out_sel_r [TERM_COUNT]; // function per terminal
  logic [ST_W-1:0]  status_r;               // sticky events
  logic [ST_W-1:0]  mask_r;                 // interrupt enables

  // bus pipeline
  logic       wr_pend_r;   // write data phase follows
  logic [7:0] wr_addr_r;   // address of that write
  logic       acc_ok;      // address phase taken
  logic [31:0] rd_nxt;     // read value for the next data phase

  // pin and watchdog state
  logic [2:0] pin_s;       // synchronised pins
  logic       net_prev_r;  // last synchronised rx level
  logic       beat_prev_r; // last synchronised heartbeat
  logic       net_kick;    // serial activity pulse
  logic       opt_kick;    // option card activity pulse
  logic [TICK_W-1:0] tick_cnt_r;
  logic       tick;        // 10 ms enable pulse
  logic       net_lost;    // serial watchdog expired
  logic       opt_wd_exp;  // option card watchdog expired
  logic       opt_ok;      // option card network healthy
  logic       opt_ok_prev_r;
  logic       net_lost_prev_r;
  logic       net_rise;    // new timeout event
  logic       opt_fall;    // option card loss event
  logic       trip_clr;    // software trip clear strobe
  logic       trip_r;      // latched communication trip
  logic       stop_r;      // decelerate-to-stop request
  logic       coast_r;     // free-run request

  // function vector and combiner
  logic [FN_COUNT-1:0] fn_vec;   // all output functions
  logic                comb_a;   // selected input a
  logic                comb_b;   // selected input b
  logic                comb_res; // boolean result

  // pick one function, the combiner itself reads as zero
  function automatic logic pick_other(input logic [3:0] code,
                                      input logic [FN_COUNT-1:0] v);
    logic res;
    res = 1'b0;
    if (code != FN_LOGIC && code < 4'(FN_COUNT)) begin
      res = v[code];
    end
    return res;
  endfunction

  // --- ahb-lite slave -------------------------------------------

  assign acc_ok      = hsel_i && htrans_i[1] && hready_i;
  assign hreadyout_o = 1'b1;  // zero wait states
  assign hresp_o     = 1'b0;  // always okay

  // read mux, unmapped addresses read as zero
  always_comb begin
    rd_nxt = '0;
    unique case (haddr_i[7:0])
      REG_CTRL:    rd_nxt[CTRL_RESP_LSB +: 3] = comm_error_response_r;
      REG_NET_TMO: rd_nxt[TMO_W-1:0] = net_timeout_period_r;
      REG_OPT_TMO: rd_nxt[TMO_W-1:0] = option_card_timeout_r;
      REG_COMB: begin
        rd_nxt[COMB_A_LSB +: 4]  = comb_a_sel_r;
        rd_nxt[COMB_B_LSB +: 4]  = comb_b_sel_r;
        rd_nxt[COMB_OP_LSB +: 2] = comb_op_sel_r;
      end
      REG_OUT_SEL: rd_nxt[7:0] = {out_sel_r[1], out_sel_r[0]};
      REG_STATUS:  rd_nxt[ST_W-1:0] = status_r;
      REG_MASK:    rd_nxt[ST_W-1:0] = mask_r;
      REG_STATE:   rd_nxt[7:0] = {2'b00, coast_r, stop_r, trip_r,
                                  opt_ok, comb_res, net_lost};
      default:     rd_nxt = '0;
    endcase
  end

  // read data registered at the address phase
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hrdata_o <= '0;
    end else if (acc_ok && !hwrite_i) begin
      hrdata_o <= rd_nxt;
    end
  end

  // remember a write address for its data phase
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      wr_pend_r <= acc_ok && hwrite_i;
      if (acc_ok) begin
        wr_addr_r <= haddr_i[7:0];
      end
    end
  end

  // configuration writes
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      comm_error_response_r <= RESP_RST;
      net_timeout_period_r  <= TMO_RST;
      option_card_timeout_r <= TMO_RST;
      comb_a_sel_r          <= '0;
      comb_b_sel_r          <= '0;
      comb_op_sel_r         <= OP_AND;
      out_sel_r[0]          <= FN_NET_LOST;
      out_sel_r[1]          <= FN_LOGIC;
      mask_r                <= '0;
    end else if (wr_pend_r) begin
      unique case (wr_addr_r)
        REG_CTRL:
          comm_error_response_r <= hwdata_i[CTRL_RESP_LSB +: 3];  // R4
        REG_NET_TMO: net_timeout_period_r <= hwdata_i[TMO_W-1:0];  // R1
        REG_OPT_TMO: option_card_timeout_r <= hwdata_i[TMO_W-1:0]; // R9
        REG_COMB: begin
          comb_a_sel_r  <= hwdata_i[COMB_A_LSB +: 4];   // R5
          comb_b_sel_r  <= hwdata_i[COMB_B_LSB +: 4];   // R5
          comb_op_sel_r <= hwdata_i[COMB_OP_LSB +: 2];  // R6
        end
        REG_OUT_SEL: begin
          out_sel_r[0] <= hwdata_i[3:0];
          out_sel_r[1] <= hwdata_i[7:4];
        end
        REG_MASK: mask_r <= hwdata_i[ST_W-1:0];
        default: ;
      endcase
    end
  end

  assign trip_clr = wr_pend_r && wr_addr_r == REG_CTRL
                    && hwdata_i[CTRL_TRIP_CLR];

  // --- watchdogs --------------------------------------------------

  nwl_sync #(.W(3)) u_sync (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .async_i   ({opt_present_i, opt_beat_i, net_rx_i}),
    .sync_o    (pin_s)
  );

  // edge detect after synchronising; any edge is activity
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      net_prev_r  <= 1'b0;
      beat_prev_r <= 1'b0;
    end else begin
      net_prev_r  <= pin_s[0];
      beat_prev_r <= pin_s[1];
    end
  end
  assign net_kick = pin_s[0] ^ net_prev_r;  // R11
  assign opt_kick = pin_s[1] ^ beat_prev_r;

  // 10 ms tick divider
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end
  assign tick = (tick_cnt_r == TICK_W'(TICK_CYCLES - 1));

  // serial network watchdog
  nwl_wdog u_net_wdog (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .tick_i    (tick),
    .kick_i    (net_kick),
    .period_i  (net_timeout_period_r),  // R1
    .expired_o (net_lost)               // R2
  );

  // option card watchdog with its own period
  nwl_wdog u_opt_wdog (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .tick_i    (tick),
    .kick_i    (opt_kick),
    .period_i  (option_card_timeout_r),  // R9
    .expired_o (opt_wd_exp)
  );
  assign opt_ok = pin_s[2] && !opt_wd_exp;  // R8

  // --- events, trip and interrupt ---------------------------------

  // previous values for event edges
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      net_lost_prev_r <= 1'b0;
      opt_ok_prev_r   <= 1'b0;
    end else begin
      net_lost_prev_r <= net_lost;
      opt_ok_prev_r   <= opt_ok;
    end
  end
  assign net_rise = net_lost && !net_lost_prev_r;
  assign opt_fall = !opt_ok && opt_ok_prev_r;

  // timeout response: trip, decelerate or coast
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      trip_r  <= 1'b0;
      stop_r  <= 1'b0;
      coast_r <= 1'b0;
    end else if (net_rise) begin
      unique case (comm_error_response_r)
        RESP_TRIP: begin
          trip_r  <= 1'b1;                                   // R4
          coast_r <= 1'b1;
        end
        RESP_STOP_TRIP: begin
          trip_r <= 1'b1;                                    // R4
          stop_r <= 1'b1;
        end
        RESP_COAST: coast_r <= 1'b1;                         // R4
        RESP_STOP:  stop_r  <= 1'b1;                         // R4
        default: ;
      endcase
    end else if (trip_clr) begin
      trip_r  <= 1'b0;
      stop_r  <= 1'b0;
      coast_r <= 1'b0;
    end
  end
  assign trip_o       = trip_r;
  assign stop_motor_o = stop_r;
  assign coast_o      = coast_r;
  assign trip_code_o  = trip_r ? COMM_TIMEOUT_TRIP_CODE : 8'h00;

  // sticky status, write one clears, a new event wins
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_r <= '0;
    end else begin
      status_r <= (status_r
                   & ~((wr_pend_r && wr_addr_r == REG_STATUS)
                       ? hwdata_i[ST_W-1:0] : '0))
                  | {net_rise && (comm_error_response_r == RESP_TRIP
                     || comm_error_response_r == RESP_STOP_TRIP),
                     opt_fall, net_rise};
    end
  end
  assign irq_o = |(status_r & mask_r);

  // --- output functions -------------------------------------------

  // feedback limits only steer the stage request, never an alarm
  assign fn_vec = {opt_ok, comb_res, net_lost,
                   second_stage_request_i, drive_func_i};  // R10

  // combiner inputs and operator
  always_comb begin
    comb_a = pick_other(comb_a_sel_r, fn_vec);  // R5
    comb_b = pick_other(comb_b_sel_r, fn_vec);  // R5
    unique case (comb_op_sel_r)
      OP_AND:  comb_res = comb_a & comb_b;      // R6
      OP_OR:   comb_res = comb_a | comb_b;      // R6
      OP_XOR:  comb_res = comb_a ^ comb_b;      // R6
      default: comb_res = 1'b0;
    endcase
  end

  // one registered output per terminal
  for (genvar t = 0; t < TERM_COUNT; t++) begin : g_term
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        out_term_o[t] <= 1'b0;
      end else if (out_sel_r[t] < 4'(FN_COUNT)) begin
        out_term_o[t] <= fn_vec[out_sel_r[t]];  // R2 R7 R8
      end else begin
        out_term_o[t] <= 1'b0;
      end
    end
  end

  // --- checks -----------------------------------------------------

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  a_kick_clears_lost: assert property ( // R3
    net_kick |=> !net_lost)
    else $error("network lost stayed on after activity");
  a_lost_needs_silence: assert property ( // R11
    $rose(net_lost) |-> !$past(net_kick))
    else $error("network lost rose right after activity");
  a_zero_period_off: assert property ( // R1
    net_timeout_period_r == '0 |=> !net_lost)
    else $error("watchdog fired with zero period");
  a_trip_on_timeout: assert property ( // R4
    net_rise && comm_error_response_r == RESP_TRIP
    |=> trip_o && coast_o && trip_code_o == COMM_TIMEOUT_TRIP_CODE)
    else $error("trip response missing");
  a_ignore_no_trip: assert property ( // R4
    net_rise && comm_error_response_r == RESP_IGNORE && !trip_r
    |=> !trip_o)
    else $error("ignore response tripped");
  a_xor_both_one: assert property ( // R6
    comb_op_sel_r == OP_XOR && comb_a && comb_b |-> !comb_res)
    else $error("xor of two ones gave one");
  a_and_result: assert property ( // R6
    comb_op_sel_r == OP_AND |-> comb_res == (comb_a && comb_b))
    else $error("and result wrong");
  a_self_select_zero: assert property ( // R5
    comb_a_sel_r == FN_LOGIC |-> !comb_a)
    else $error("combiner selected its own output");
  a_term_logic: assert property ( // R7
    out_sel_r[1] == FN_LOGIC && $stable(out_sel_r[1])
    |-> out_term_o[1] == $past(comb_res))
    else $error("logic terminal does not follow result");
  a_term_net_lost: assert property ( // R2
    out_sel_r[0] == FN_NET_LOST ##1 out_sel_r[0] == FN_NET_LOST
    |-> out_term_o[0] == $past(net_lost))
    else $error("network lost terminal wrong");
  a_opt_absent_off: assert property ( // R8
    !pin_s[2] |-> !opt_ok)
    else $error("option ok without card");
  a_status_set_wins: assert property ( // R2
    net_rise |=> status_r[ST_NET_LOST])
    else $error("timeout event lost in status");

  c_net_trip:   cover property (net_rise ##1 trip_o);
  c_opt_lost:   cover property (opt_fall);
  c_xor_ones:   cover property (comb_op_sel_r == OP_XOR
                                && comb_a && comb_b);
  c_irq_raised: cover property (!irq_o ##1 irq_o);

  // hsize and upper address bits are unused: word access only
  logic unused_ok;
  assign unused_ok = ^{hsize_i, haddr_i[31:8]};
endmodule // nwl_top

//--- design/nwl_pkg.sv
// constants shared by the network watchdog and logic output block
package nwl_pkg;
  // register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_NET_TMO = 8'h04;
  localparam logic [7:0] REG_OPT_TMO = 8'h08;
  localparam logic [7:0] REG_COMB    = 8'h0c;
  localparam logic [7:0] REG_OUT_SEL = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;
  localparam logic [7:0] REG_MASK    = 8'h18;
  localparam logic [7:0] REG_STATE   = 8'h1c;
  // ctrl fields
  localparam int CTRL_RESP_LSB = 0;   // comm_error_response, 3 bits
  localparam int CTRL_TRIP_CLR = 8;   // write one to clear a trip
  // combiner fields
  localparam int COMB_A_LSB  = 0;     // combiner_input_a_sel, 4 bits
  localparam int COMB_B_LSB  = 4;     // combiner_input_b_sel, 4 bits
  localparam int COMB_OP_LSB = 8;     // combiner_operator_sel, 2 bits
  // status and mask bit positions
  localparam int ST_NET_LOST = 0;
  localparam int ST_OPT_LOST = 1;
  localparam int ST_TRIP     = 2;
  localparam int ST_W        = 3;
  // output function codes
  localparam logic [3:0] FN_NET_LOST = 4'h8;
  localparam logic [3:0] FN_LOGIC    = 4'h9;
  localparam logic [3:0] FN_OPT_OK   = 4'ha;
  localparam logic [3:0] FN_FBV      = 4'h7;
  localparam int         FN_COUNT    = 11;
  localparam int         DRV_FN_W    = 7;  // codes 00..06 from the drive
  localparam int         TERM_COUNT  = 2;
  // combiner operator codes
  localparam logic [1:0] OP_AND = 2'h0;
  localparam logic [1:0] OP_OR  = 2'h1;
  localparam logic [1:0] OP_XOR = 2'h2;
  // communication error responses
  localparam logic [2:0] RESP_TRIP      = 3'h0;
  localparam logic [2:0] RESP_STOP_TRIP = 3'h1;
  localparam logic [2:0] RESP_IGNORE    = 3'h2;
  localparam logic [2:0] RESP_COAST     = 3'h3;
  localparam logic [2:0] RESP_STOP      = 3'h4;
  // alarm code shown on a communication trip (60)
  localparam logic [7:0] COMM_TIMEOUT_TRIP_CODE = 8'h3c;
  // timeout settings count in 10 ms units; zero disables the watchdog
  localparam int TMO_W     = 16;
  localparam int CLK_NS    = 5;
  localparam int TICK_NS   = 10000000;
  localparam int TICK_CYC  = TICK_NS / CLK_NS;
  localparam int TICK_W    = 21;
  // reset values
  localparam logic [TMO_W-1:0] TMO_RST = 16'h0000;
  localparam logic [2:0]       RESP_RST = RESP_IGNORE;
endpackage : nwl_pkg

//--- design/nwl_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module nwl_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_r;  // first stage, read only by the second

  // two stages, cleared under reset
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule // nwl_sync

//--- design/nwl_wdog.sv
// tick-based watchdog timer, restarted by a kick pulse
`timescale 1ns/100ps
module nwl_wdog
  import nwl_pkg::*;
(
  input  wire logic             sys_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             tick_i,     // one pulse per 10 ms
  input  wire logic             kick_i,     // activity seen
  input  wire logic [TMO_W-1:0] period_i,   // timeout in ticks, 0 = off
  output logic                  expired_o   // high after timeout
);
  logic [TMO_W-1:0] cnt_r;  // ticks since last kick

  // count silence; any kick restarts from zero
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_r <= '0;
    end else if (kick_i) begin
      cnt_r <= '0;                                     // R11
    end else if (tick_i && cnt_r != period_i) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // expiry flag; a zero period keeps it low
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      expired_o <= 1'b0;
    end else if (kick_i || period_i == '0) begin
      expired_o <= 1'b0;                               // R3
    end else begin
      expired_o <= (cnt_r == period_i);
    end
  end
endmodule // nwl_wdog

//--- testbench/nwl_partner.sv
// host and option card model driving the activity pins
`timescale 1ns/100ps
module nwl_partner (
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  input  wire logic net_en_i,    // host keeps sending frames
  input  wire logic opt_en_i,    // card keeps beating
  input  wire logic present_i,   // card network up
  input  wire logic slow_i,      // long gaps between frames
  output logic      net_rx_o,
  output logic      opt_beat_o,
  output logic      opt_present_o
);
  logic [3:0] gap_r;  // cycles since last activity edge

  // slow gaps of ten cycles outlast one tick but end before a two-tick
  // period can expire, so only a restart of the count on every edge
  // keeps the watchdog quiet; >= lets a mode change resume at once
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap_r         <= 4'h0;
      net_rx_o      <= 1'b1;  // serial line idles high
      opt_beat_o    <= 1'b0;
      opt_present_o <= 1'b0;
    end else begin
      opt_present_o <= present_i;
      if (gap_r >= (slow_i ? 4'h9 : 4'h3)) begin
        gap_r <= 4'h0;
        if (net_en_i) begin
          net_rx_o <= ~net_rx_o;
        end
        if (opt_en_i) begin
          opt_beat_o <= ~opt_beat_o;
        end
      end else begin
        gap_r <= gap_r + 4'h1;
      end
    end
  end
endmodule // nwl_partner

//--- testbench/nwl_top_test.sv
// self-checking bench for the watchdog and logic output block
`timescale 1ns/100ps
module nwl_top_test;
  import nwl_pkg::*;
  logic        sys_clk_i;
  logic        resetn_i;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        net_rx, opt_beat, opt_present;
  logic [6:0]  drive_func;
  logic        ssr;
  logic [1:0]  out_term;
  logic        trip, stop, coast, irq;
  logic [7:0]  trip_code;
  logic        net_en, opt_en, present, slow;
  logic        dp_rd, look_r;  // read data phase, output probe
  logic [31:0] expq[$];        // expected results in order
  int          n_mismatch, checks, cyc;

  nwl_top #(.TICK_CYCLES(8)) uut (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
    .net_rx_i(net_rx), .opt_beat_i(opt_beat),
    .opt_present_i(opt_present), .drive_func_i(drive_func),
    .second_stage_request_i(ssr), .out_term_o(out_term),
    .trip_o(trip), .trip_code_o(trip_code), .stop_motor_o(stop),
    .coast_o(coast), .irq_o(irq));

  nwl_partner far (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .net_en_i(net_en),
    .opt_en_i(opt_en), .present_i(present), .slow_i(slow),
    .net_rx_o(net_rx), .opt_beat_o(opt_beat),
    .opt_present_o(opt_present));

  // 200 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic finish_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen,
               exp);
    end
  endtask

  // wait for the edge where the slave shows ready
  task automatic wait_rdy;
    do @(posedge sys_clk_i); while (hreadyout !== 1'b1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= 1'b1;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    hsel <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk_i);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= 1'b0;
    wait_rdy;
    htrans <= 2'b00;
    dp_rd  <= 1'b1;
    expq.push_back(e);
    wait_rdy;
    dp_rd <= 1'b0;
    hsel  <= 1'b0;
  endtask

  // probe the pin outputs at the edge after the next
  task automatic look(input logic [13:0] e);
    @(posedge sys_clk_i);
    look_r <= 1'b1;
    expq.push_back({18'h0, e});
    @(posedge sys_clk_i);
    look_r <= 1'b0;
  endtask

  function automatic logic [13:0] outs(input logic i, input logic c,
      input logic s, input logic t, input logic [1:0] o);
    return {i, c, s, t, t ? COMM_TIMEOUT_TRIP_CODE : 8'h00, o};
  endfunction

  // watcher: compare each result with the oldest note
  always @(posedge sys_clk_i) begin
    if (look_r) begin
      check({17'h0, hresp, irq, coast, stop, trip, trip_code, out_term},
            expq.pop_front());
    end else if (dp_rd && hreadyout === 1'b1) begin
      check(hrdata, expq.pop_front());
    end
  end

  // hang guard
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test;
    end
  end

  initial begin
    logic [2:0] rs[5];
    logic [2:0] r;
    logic       tr, st, co, e;
    logic [3:0] a, b;
    logic [7:0] v;
    logic [10:0] ev;  // all function codes; 08..10 read zero here
    rs = '{RESP_TRIP, RESP_STOP_TRIP, RESP_COAST, RESP_STOP, RESP_IGNORE};
    void'($urandom(32'ha02777b3));
    {resetn_i, hsel, haddr, htrans, hwrite, hwdata} = '0;
    {drive_func, ssr, net_en, opt_en, present, slow} = '0;
    {dp_rd, look_r} = '0;
    n_mismatch = 0;
    checks = 0;
    cyc = 0;
    repeat (10) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    rd(REG_CTRL, {29'h0, RESP_RST});
    rd(REG_NET_TMO, 32'h0);
    rd(REG_COMB, 32'h0);
    rd(REG_OUT_SEL, 32'h98);
    rd(REG_MASK, 32'h0);
    rd(8'h20, 32'h0);
    net_en <= 1'b1;
    slow   <= 1'b1;
    wr(REG_MASK, 32'h7);
    wr(REG_NET_TMO, 32'h2);
    repeat (100) @(posedge sys_clk_i);
    look(14'h0);
    slow <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      r  = rs[i];
      tr = (r == RESP_TRIP) || (r == RESP_STOP_TRIP);
      st = (r == RESP_STOP_TRIP) || (r == RESP_STOP);
      co = (r == RESP_TRIP) || (r == RESP_COAST);
      net_en <= 1'b1;
      repeat (20) @(posedge sys_clk_i);
      wr(REG_CTRL, 32'h100 | r);
      wr(REG_STATUS, 32'h7);
      look(14'h0);
      net_en <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      look(14'h0);
      repeat (50) @(posedge sys_clk_i);
      look(outs(1'b1, co, st, tr, 2'b01));
      rd(REG_STATUS, {29'h0, tr, 1'b0, 1'b1});
    end
    wr(REG_MASK, 32'h0);
    look(outs(1'b0, 1'b0, 1'b0, 1'b0, 2'b01));
    wr(REG_STATUS, 32'h7);
    net_en <= 1'b1;
    wr(REG_OUT_SEL, {24'h0, FN_LOGIC, FN_OPT_OK});
    for (int op = 0; op < 4; op++) begin
      for (int k = 0; k < 3; k++) begin
        a = 4'($urandom_range(10));
        b = 4'($urandom_range(10));
        v = 8'($urandom);
        // traffic runs (no loss), self reads zero, card absent
        ev = {3'b000, v};
        wr(REG_COMB, {22'h0, 2'(op), b, a});
        drive_func <= v[6:0];
        ssr        <= v[7];
        repeat (4) @(posedge sys_clk_i);
        case (op)
          0: e = ev[a] & ev[b];
          1: e = ev[a] | ev[b];
          2: e = ev[a] ^ ev[b];
          default: e = 1'b0;
        endcase
        look(outs(1'b0, 1'b0, 1'b0, 1'b0, {e, 1'b0}));
      end
    end
    present <= 1'b1;
    opt_en  <= 1'b1;
    wr(REG_OPT_TMO, 32'h2);
    wr(REG_MASK, 32'h2);
    repeat (30) @(posedge sys_clk_i);
    rd(REG_STATE, 32'h4);
    look(14'h1);
    opt_en <= 1'b0;
    repeat (60) @(posedge sys_clk_i);
    look(outs(1'b1, 1'b0, 1'b0, 1'b0, 2'b00));
    rd(REG_STATUS, 32'h2);
    present <= 1'b0;
    opt_en  <= 1'b1;
    wr(REG_STATUS, 32'h7);
    repeat (30) @(posedge sys_clk_i);
    look(14'h0);
    finish_test;
  end
endmodule // nwl_top_test
